// ===== hw/coproc_convert_divide_issue.sv
// Host issue logic for coprocessor conversion and double divide commands
`timescale 1ns/1ns
`include "coproc_issue_consts.svh"

module coproc_convert_divide_issue
  import coproc_issue_pkg::*;
(
  input  wire logic                         clk_sys,
  input  wire logic                         rst,
  input  wire logic                         req_valid,
  output logic                              req_ready,
  input  wire coproc_issue_pkg::issue_req_s req_in,
  output coproc_issue_pkg::cop_beat_s       beat,
  output logic                              busy
);
  import coproc_issue_pkg::*;

  // ---------------------------------------------------------------
  // Request selection and operand word
  // ---------------------------------------------------------------
  issue_state_e state_q;
  issue_req_s   req_q;
  issue_req_s   src_req;
  logic [1:0]   step_q;
  logic [2:0]   total_q;
  logic [3:0]   mid;
  logic [15:0]  opw;
  logic         take;

  assign req_ready = (state_q == ST_IDLE);
  assign busy      = (state_q == ST_ISSUE);
  assign take      = req_valid && req_ready;
  assign src_req   = take ? req_in : req_q;

  always_comb begin
    case (src_req.cmd)
      double_to_int_convert:    mid = `CODE_TO_INT;
      single_to_double_convert: mid = `CODE_TO_DBL;
      single_to_int_convert:    mid = `CODE_TO_INT;
      int_to_double_convert:    mid = `CODE_FROM_INT;
      int_to_single_convert:    mid = `CODE_FROM_INT;
      double_divide:            mid = src_req.coproc_src2_reg;
      default:                  mid = 4'h0;
    endcase
  end

  coproc_operand_word u_opw (
    .sel  (`COP_SELECT),
    .src  (src_req.coproc_source_reg),
    .mid  (mid),
    .dst  (src_req.coproc_dest_reg),
    .word (opw)
  );

  // ---------------------------------------------------------------
  // Schedule helpers
  // ---------------------------------------------------------------
  function automatic logic load_form(input issue_req_s r);
    load_form = r.is_load && (r.cmd != double_to_int_convert) && (r.cmd != double_divide);
  endfunction : load_form

  function automatic logic [2:0] state_count(input issue_req_s r);
    if (!load_form(r)) begin
      state_count = `STATES_SHORT;
    end else if (r.cmd == int_to_double_convert) begin
      state_count = r.aligned ? `STATES_TWO_AL : `STATES_TWO_UN;
    end else begin
      state_count = r.aligned ? `STATES_ONE_AL : `STATES_ONE_UN;
    end
  endfunction : state_count

  function automatic cop_beat_s schedule(input issue_req_s r, input logic [15:0] op, input logic [1:0] step);
    cop_beat_s   b;
    logic [15:0] first;
    logic [15:0] second;
    logic        two;
    b      = '0;
    two    = (r.cmd == int_to_double_convert);
    second = (two ? `W_SECOND_TWO : `W_SECOND_ONE)
             | (two ? {11'h000, r.host_file, r.host_src_register} : 16'h0000);
    if (load_form(r)) begin
      first = (two ? `W_LOAD_TWO : `W_LOAD_ONE) | {11'h000, r.host_file, r.host_src_register};
    end else if (r.cmd == double_divide) begin
      first = `W_SHORT_DDIV;
    end else if (r.cmd == double_to_int_convert || r.cmd == int_to_double_convert) begin
      first = `W_SHORT_FROM_DI;
    end else begin
      first = `W_SHORT_FROM_S;
    end
    b.data = r.host_data;
    if (!load_form(r)) begin
      b.word0_valid = 1'b1;
      b.word0       = (step == 2'd0) ? first : op;
    end else if (r.aligned) begin
      case (step)
        2'd0: begin
          b.word0_valid = 1'b1;
          b.word0       = first;
        end
        2'd1: begin
          b.word0_valid = 1'b1;
          b.word0       = second;
          b.word1_valid = 1'b1;
          b.word1       = op;
        end
        default: begin
          b.data_valid = 1'b1;
        end
      endcase
    end else begin
      case (step)
        2'd0: begin
          b.word0_valid = 1'b1;
          b.word0       = first;
          b.word1_valid = 1'b1;
          b.word1       = second;
        end
        2'd1: begin
          b.word0_valid = 1'b1;
          b.word0       = op;
          b.data_valid  = 1'b1;
        end
        default: begin
          b.data_valid = 1'b1;
        end
      endcase
    end
    schedule = b;
  endfunction : schedule

  // ---------------------------------------------------------------
  // State machine
  // ---------------------------------------------------------------
  logic last_step;
  assign last_step = ({1'b0, step_q} == total_q - 3'd1);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:  if (take) state_q <= ST_ISSUE;
        ST_ISSUE: if (last_step) state_q <= ST_IDLE;
        default:  state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      req_q   <= '0;
      total_q <= 3'd0;
    end else if (take) begin
      req_q   <= req_in;
      total_q <= state_count(req_in);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      step_q <= 2'd0;
    end else if (take) begin
      step_q <= 2'd0;
    end else if (busy && !last_step) begin
      step_q <= step_q + 2'd1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      beat <= '0;
    end else if (take) begin
      beat <= schedule(req_in, opw, 2'd0);
    end else if (busy && !last_step) begin
      beat <= schedule(req_q, opw, step_q + 2'd1);
    end else begin
      beat <= '0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic one_load_in;
  logic two_load_in;
  assign one_load_in = take && load_form(req_in) && (req_in.cmd != int_to_double_convert);
  assign two_load_in = take && load_form(req_in) && (req_in.cmd == int_to_double_convert);

  sequence s_hold2;
    busy [*2] ##1 !busy;
  endsequence
  sequence s_hold3;
    busy [*3] ##1 !busy;
  endsequence
  sequence s_hold4;
    busy [*4] ##1 !busy;
  endsequence
  sequence s_both_halves;
    ##[1:2] beat.data_valid ##1 (beat.data_valid && beat.data == $past(beat.data));
  endsequence

  AST_SHORT_STATES: assert property (take && !load_form(req_in) |=> s_hold2)
    else $error("Short command did not last two states");
  AST_ONE_ALIGNED: assert property (one_load_in && req_in.aligned |=> s_hold3)
    else $error("Aligned one-register load did not last three states");
  AST_ONE_UNALIGNED: assert property (one_load_in && !req_in.aligned |=> s_hold2)
    else $error("Unaligned one-register load did not last two states");
  AST_TWO_ALIGNED: assert property (two_load_in && req_in.aligned |=> s_hold4)
    else $error("Aligned integer-to-double load did not last four states");
  AST_TWO_UNALIGNED: assert property (two_load_in && !req_in.aligned |=> s_hold3)
    else $error("Unaligned integer-to-double load did not last three states");
  AST_BOTH_HALVES: assert property (two_load_in |=> s_both_halves)
    else $error("Host register not sent as both halves");
  AST_LOAD_DATA: assert property (one_load_in && req_in.aligned |=> ##2
      (beat.data_valid && beat.data == $past(req_in.host_data, 3)))
    else $error("Host register not copied to coprocessor");
  AST_LOAD_FIRST: assert property (take && load_form(req_in) |=>
      (beat.word0_valid && beat.word0[15:7] == 9'h00c))
    else $error("Load form did not open with its first word");
  AST_DBL_INT_CODE: assert property (take && !load_form(req_in) && req_in.cmd == double_to_int_convert
      |=> ##1 (beat.word0[8:5] == `CODE_TO_INT && beat.word0[15:13] == `COP_SELECT))
    else $error("Double-to-integer operand word wrong");
  AST_DIV_FIELDS: assert property (take && req_in.cmd == double_divide |=> ##1
      (beat.word0[8:5] == $past(req_in.coproc_src2_reg, 2) && beat.word0[4:0] == $past(req_in.coproc_dest_reg, 2)))
    else $error("Divide operand word wrong");
  AST_SGL_DBL_CODE: assert property (take && !load_form(req_in) && req_in.cmd == single_to_double_convert
      |=> ##1 (beat.word0[8:5] == `CODE_TO_DBL))
    else $error("Single-to-double code wrong");
  AST_INT_CODE: assert property (take && !load_form(req_in) && req_in.cmd == int_to_single_convert
      |=> ##1 (beat.word0[8:5] == `CODE_FROM_INT && beat.word0[12:9] == $past(req_in.coproc_source_reg, 2)))
    else $error("Integer-to-single operand word wrong");

  // ---------------------------------------------------------------
  // Per-command word checks, then word order, idle and busy-refusal checks
  // ---------------------------------------------------------------
  AST_SGL_INT_CODE: assert property (take && !load_form(req_in) && req_in.cmd == single_to_int_convert
      |=> ##1 (beat.word0[8:5] == `CODE_TO_INT))
    else $error("Single-to-integer code wrong");
  AST_INT_DBL_CODE: assert property (take && !load_form(req_in) && req_in.cmd == int_to_double_convert
      |=> ##1 (beat.word0[8:5] == `CODE_FROM_INT))
    else $error("Integer-to-double code wrong");
  AST_SELECT_FIELD: assert property (take && !load_form(req_in) |=> ##1
      (beat.word0[15:13] == `COP_SELECT && beat.word0[4:0] == $past(req_in.coproc_dest_reg, 2)))
    else $error("Operand word select or destination wrong");
  AST_CMD_FIRST: assert property (take && !load_form(req_in) && req_in.cmd != double_divide |=>
      (beat.word0_valid && beat.word0[15:1] == 15'h6c1f && !beat.word1_valid))
    else $error("Short conversion did not open with its first word");
  AST_DIV_FIRST: assert property (take && req_in.cmd == double_divide |=>
      (beat.word0_valid && beat.word0 == `W_SHORT_DDIV))
    else $error("Divide did not open with its first word");
  AST_ONE_AL_SECOND: assert property (one_load_in && req_in.aligned |=> ##1
      (beat.word0 == `W_SECOND_ONE && beat.word1_valid && beat.word1[12:9] == $past(req_in.coproc_source_reg, 2)))
    else $error("Aligned one-register load second step wrong");
  AST_ONE_UN_DATA: assert property (one_load_in && !req_in.aligned |=> ##1
      (beat.data_valid && beat.data == $past(req_in.host_data, 2)
       && beat.word0[12:9] == $past(req_in.coproc_source_reg, 2)))
    else $error("Unaligned one-register load data wrong");
  AST_SGL_INT_LOAD: assert property (one_load_in && req_in.aligned && req_in.cmd == single_to_int_convert
      |=> ##1 (beat.word1[8:5] == `CODE_TO_INT))
    else $error("Load single-to-integer code wrong");
  AST_INT_SGL_LOAD: assert property (one_load_in && !req_in.aligned && req_in.cmd == int_to_single_convert
      |=> ##1 (beat.word0[8:5] == `CODE_FROM_INT))
    else $error("Load integer-to-single code wrong");
  AST_SGL_DBL_LOAD: assert property (one_load_in && !req_in.aligned && req_in.cmd == single_to_double_convert
      |=> ##1 (beat.word0[8:5] == `CODE_TO_DBL))
    else $error("Load single-to-double code wrong");
  AST_TWO_SECOND: assert property (two_load_in && req_in.aligned |=> ##1
      (beat.word0 == (`W_SECOND_TWO | {11'h000, $past(req_in.host_file, 2), $past(req_in.host_src_register, 2)})))
    else $error("Integer-to-double second word wrong");
  AST_TWO_UN_OPERAND: assert property (two_load_in && !req_in.aligned |=> ##1
      (beat.word0[8:5] == `CODE_FROM_INT && beat.data_valid && beat.data == $past(req_in.host_data, 2)))
    else $error("Unaligned integer-to-double operand step wrong");
  AST_WORD_ORDER: assert property (beat.word1_valid |-> beat.word0_valid)
    else $error("Second word slot used without the first");
  AST_IDLE_QUIET: assert property (!busy |-> (beat == '0))
    else $error("Beat not quiet while idle");
  AST_REFUSE_BUSY: assert property (busy && req_valid |=> $stable(req_q))
    else $error("Request taken while busy");

endmodule : coproc_convert_divide_issue

// ===== hw/coproc_operand_word.sv
// Operand word assembly for coprocessor commands
`timescale 1ns/1ns
`include "coproc_issue_consts.svh"

module coproc_operand_word (
  input  wire logic [2:0]  sel,
  input  wire logic [3:0]  src,
  input  wire logic [3:0]  mid,
  input  wire logic [4:0]  dst,
  output logic      [15:0] word
);

  always_comb begin
    word = 16'h0000;
    word[`OPW_SEL_HI:`OPW_SEL_LO] = sel;
    word[`OPW_SRC_HI:`OPW_SRC_LO] = src;
    word[`OPW_MID_HI:`OPW_MID_LO] = mid;
    word[`OPW_DST_HI:`OPW_DST_LO] = dst;
  end

endmodule : coproc_operand_word

// ===== include/coproc_issue_consts.svh
// Encodings, field positions and state counts for coprocessor issue
`ifndef COPROC_ISSUE_CONSTS_SVH
`define COPROC_ISSUE_CONSTS_SVH

// -----------------------------------------------------------------
// Operand word field positions
// -----------------------------------------------------------------
`define OPW_SEL_HI      15
`define OPW_SEL_LO      13
`define OPW_SRC_HI      12
`define OPW_SRC_LO      9
`define OPW_MID_HI      8
`define OPW_MID_LO      5
`define OPW_DST_HI      4
`define OPW_DST_LO      0

// Coprocessor select value, arbitrary
`define COP_SELECT      3'h0

// -----------------------------------------------------------------
// Instruction word encodings
// -----------------------------------------------------------------
`define W_SHORT_FROM_DI 16'hd83f
`define W_SHORT_FROM_S  16'hd83e
`define W_SHORT_DDIV    16'hd827
`define W_LOAD_ONE      16'h0620
`define W_LOAD_TWO      16'h0640
`define W_SECOND_ONE    16'h5f00
`define W_SECOND_TWO    16'h5f80

// Conversion codes
`define CODE_TO_DBL     4'h4
`define CODE_TO_INT     4'h5
`define CODE_FROM_INT   4'h6

// -----------------------------------------------------------------
// Machine state counts
// -----------------------------------------------------------------
`define STATES_SHORT    3'd2
`define STATES_ONE_AL   3'd3
`define STATES_ONE_UN   3'd2
`define STATES_TWO_AL   3'd4
`define STATES_TWO_UN   3'd3

`endif

// ===== include/coproc_issue_pkg.sv
// Types for coprocessor convert and divide issue
package coproc_issue_pkg;

  typedef enum logic [5:0] {
    double_to_int_convert = 6'b000001,
    single_to_double_convert = 6'b000010,
    single_to_int_convert = 6'b000100,
    int_to_double_convert = 6'b001000,
    int_to_single_convert = 6'b010000,
    double_divide = 6'b100000
  } cmd_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_ISSUE = 2'b10
  } issue_state_e;

  typedef struct packed {
    cmd_e        cmd;
    logic        is_load;
    logic        aligned;
    logic        host_file;
    logic [3:0]  host_src_register;
    logic [31:0] host_data;
    logic [3:0]  coproc_source_reg;
    logic [3:0]  coproc_src2_reg;
    logic [4:0]  coproc_dest_reg;
  } issue_req_s;

  typedef struct packed {
    logic        word0_valid;
    logic [15:0] word0;
    logic        word1_valid;
    logic [15:0] word1;
    logic        data_valid;
    logic [31:0] data;
  } cop_beat_s;

endpackage : coproc_issue_pkg

// ===== verification/coproc_model.sv
// Behavioural coprocessor that sinks issued command words and data
`timescale 1ns/1ns

module coproc_model
  import coproc_issue_pkg::*;
(
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  input  wire coproc_issue_pkg::cop_beat_s beat
);
  import coproc_issue_pkg::*;

  int          n_words;
  int          n_data;
  logic [63:0] xfer_q;
  logic [15:0] op_word_q;

  // ---------------------------------------------
  // Word and data intake
  // ---------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      n_words      <= 0;
      n_data       <= 0;
      xfer_q       <= '0;
      op_word_q    <= '0;
    end else begin
      n_words <= n_words + int'(beat.word0_valid) + int'(beat.word1_valid);
      if (beat.data_valid) begin
        n_data <= n_data + 1;
        xfer_q <= {xfer_q[31:0], beat.data};
      end
      if (beat.word1_valid) begin
        op_word_q <= beat.word1;
      end else if (beat.word0_valid) begin
        op_word_q <= beat.word0;
      end
    end
  end
endmodule : coproc_model

// ===== verification/testbench.sv
// Self-checking bench for coprocessor convert and divide issue
`timescale 1ns/1ns

module testbench;
  import coproc_issue_pkg::*;

  logic        clk_sys;
  logic        rst;
  logic        req_valid;
  logic        req_ready;
  issue_req_s  req_in;
  cop_beat_s   beat;
  logic        busy;
  int          err_count;
  int          n_tests;
  int          cycles;
  int          exp_words;
  int          exp_data;
  logic [31:0] seed;
  logic [15:0] exp_op;
  cop_beat_s   eq[$];
  cmd_e        cmds[6] = '{double_to_int_convert, single_to_double_convert, single_to_int_convert,
                           int_to_double_convert, int_to_single_convert, double_divide};

  coproc_convert_divide_issue dut (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .req_valid (req_valid),
    .req_ready (req_ready),
    .req_in    (req_in),
    .beat      (beat),
    .busy      (busy)
  );

  coproc_model cop (
    .clk_sys (clk_sys),
    .rst     (rst),
    .beat    (beat)
  );

  // ---------------------------------------------
  // Clock and timeout
  // ---------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      stop_test();
    end
  end

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  function automatic cop_beat_s mk(input logic v0, input logic [15:0] w0, input logic v1,
                                   input logic [15:0] w1, input logic dv, input logic [31:0] d);
    return '{v0, w0, v1, w1, dv, d};
  endfunction : mk

  task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("errors %0d comparisons %0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test

  // Reference model of the issued beats
  function automatic void build(input issue_req_s r);
    logic [15:0] op;
    logic [15:0] fw;
    logic [15:0] hr;
    logic [3:0]  mid;
    logic [31:0] d;
    logic        two;
    logic        ld;
    eq.delete();
    two = (r.cmd == int_to_double_convert);
    ld  = r.is_load && r.cmd != double_to_int_convert && r.cmd != double_divide;
    hr  = {11'h000, r.host_file, r.host_src_register};
    d   = r.host_data;
    case (r.cmd)
      double_to_int_convert, single_to_int_convert: mid = 4'h5;
      single_to_double_convert: mid = 4'h4;
      double_divide: mid = r.coproc_src2_reg;
      default: mid = 4'h6;
    endcase
    op = {3'h0, r.coproc_source_reg, mid, r.coproc_dest_reg};
    fw = (r.cmd == double_divide) ? 16'hd827 : (two || r.cmd == double_to_int_convert) ? 16'hd83f : 16'hd83e;
    if (!ld) begin
      eq.push_back(mk(1, fw, 0, 0, 0, 0));
      eq.push_back(mk(1, op, 0, 0, 0, 0));
    end else if (!two && r.aligned) begin
      eq.push_back(mk(1, 16'h0620 | hr, 0, 0, 0, 0));
      eq.push_back(mk(1, 16'h5f00, 1, op, 0, 0));
      eq.push_back(mk(0, 0, 0, 0, 1, d));
    end else if (!two) begin
      eq.push_back(mk(1, 16'h0620 | hr, 1, 16'h5f00, 0, 0));
      eq.push_back(mk(1, op, 0, 0, 1, d));
    end else if (r.aligned) begin
      eq.push_back(mk(1, 16'h0640 | hr, 0, 0, 0, 0));
      eq.push_back(mk(1, 16'h5f80 | hr, 1, op, 0, 0));
      eq.push_back(mk(0, 0, 0, 0, 1, d));
      eq.push_back(mk(0, 0, 0, 0, 1, d));
    end else begin
      eq.push_back(mk(1, 16'h0640 | hr, 1, 16'h5f80 | hr, 0, 0));
      eq.push_back(mk(1, op, 0, 0, 1, d));
      eq.push_back(mk(0, 0, 0, 0, 1, d));
    end
    exp_op = op;
    // Data lines carry the host value on every beat of a command
    foreach (eq[i]) eq[i].data = d;
  endfunction : build

  // Issue one command, held up while busy so repeats are refused
  task automatic run(input issue_req_s r);
    build(r);
    chk({busy, req_ready, beat}, {1'b0, 1'b1, cop_beat_s'(0)});
    req_valid = 1'b1;
    req_in    = r;
    for (int i = 0; i < eq.size(); i++) begin
      @(negedge clk_sys);
      chk(beat, eq[i]);
      chk({busy, req_ready}, 2'b10);
      exp_words += int'(eq[i].word0_valid) + int'(eq[i].word1_valid);
      exp_data  += int'(eq[i].data_valid);
    end
    @(negedge clk_sys);
    chk(cop.op_word_q, exp_op);
    if (r.is_load && r.cmd == int_to_double_convert) begin
      chk(cop.xfer_q, {2{r.host_data}});
    end
  endtask : run

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    issue_req_s r;
    err_count = 0;
    n_tests   = 0;
    cycles    = 0;
    exp_words = 0;
    exp_data  = 0;
    seed      = 32'hb7b6f513;
    rst       = 1'b1;
    req_valid = 1'b0;
    req_in    = '0;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    for (int k = 0; k < 72; k++) begin
      seed                = lfsr(seed);
      r.cmd               = cmds[(k < 24) ? k / 4 : seed % 6];
      r.is_load           = (k < 24) ? k[0] : seed[3];
      r.aligned           = (k < 24) ? k[1] : seed[4];
      r.host_file         = seed[5];
      r.host_src_register = seed[9:6];
      r.coproc_source_reg = seed[13:10];
      r.coproc_src2_reg   = seed[17:14];
      r.coproc_dest_reg   = seed[22:18];
      seed                = lfsr(seed);
      r.host_data         = seed;
      run(r);
    end
    req_valid = 1'b0;
    @(negedge clk_sys);
    chk(cop.n_words, exp_words);
    chk(cop.n_data, exp_data);
    stop_test();
  end
endmodule : testbench
